// ===== src/arb_table_if.sv
// Purpose: Carries table write, load request and status between blocks
// Assumes: Single clock domain
// Notes:   Pulses last one cycle
`timescale 1ns/1ps
`default_nettype none
interface arb_table_if;
   logic load_req;
   logic table_wr;
   logic stale;
   logic loading;

   modport ctl (output load_req, output table_wr, input stale, input loading);
   modport trk (input load_req, input table_wr, output stale, output loading);
endinterface : arb_table_if
`default_nettype wire

// ===== src/arb_table_tracker.sv
// Purpose: Tracks whether the arbitration table is coherent with the arbiter
// Assumes: load_done is a one-cycle pulse from the arbiter, same clock
// Notes:   A table write always wins over a finishing load
`timescale 1ns/1ps
`default_nettype none
module arb_table_tracker (
   // Clock and reset
   input  wire logic  aclk,
   input  wire logic  aresetn,
   // Control side
   arb_table_if.trk   tbl,
   // Arbiter side
   input  wire logic  load_done
);

   vc_res_pkg::load_state_t state_ff;
   logic                    stale_ff;
   logic                    dirty_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= vc_res_pkg::LOAD_IDLE;
      end else if (tbl.load_req) begin
         state_ff <= vc_res_pkg::LOAD_BUSY;
      end else if (load_done) begin
         state_ff <= vc_res_pkg::LOAD_IDLE;
      end
   end

   // Writes seen during a load keep the table stale afterwards
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dirty_ff <= 1'b0;
      end else if (tbl.load_req) begin
         dirty_ff <= tbl.table_wr;
      end else if (tbl.table_wr && state_ff == vc_res_pkg::LOAD_BUSY) begin
         dirty_ff <= 1'b1;
      end else if (load_done) begin
         dirty_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stale_ff <= 1'b0;
      end else if (tbl.table_wr) begin
         stale_ff <= 1'b1;
      end else if (state_ff == vc_res_pkg::LOAD_BUSY && load_done && !tbl.load_req) begin
         stale_ff <= dirty_ff;
      end
   end

   assign tbl.stale   = stale_ff;
   assign tbl.loading = (state_ff == vc_res_pkg::LOAD_BUSY);

endmodule : arb_table_tracker
`default_nettype wire

// ===== src/vc_res_pkg.sv
// Purpose: Shared constants and types for the channel resource registers
// Assumes: 32-bit register words on a 12-bit byte address
// Notes:   Only the upper control fields and the status flags live here
package vc_res_pkg;

   // Bus geometry
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam int          STRB_W      = 4;
   localparam int          WORD_LSB    = 2;

   // Register byte offsets
   localparam logic [11:0] CTL_OFFSET  = 12'h114;
   localparam logic [11:0] STS_OFFSET  = 12'h118;

   // Control register field layout
   localparam int          LOAD_BIT    = 16;
   localparam int          SEL_LSB     = 17;
   localparam int          SEL_W       = 3;
   localparam int          CHID_LSB    = 24;
   localparam int          CHID_W      = 3;
   localparam int          EN_BIT      = 31;
   localparam int          SEL_LANE    = 2;

   // Status register field layout
   localparam int          STALE_BIT   = 0;
   localparam int          PEND_BIT    = 1;

   // Reset and fixed values
   localparam logic [2:0]  SEL_RST     = 3'h0;
   localparam logic [2:0]  CHID_VAL    = 3'h0;
   localparam logic        EN_VAL      = 1'b1;
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   // Register select codes
   typedef enum logic [1:0] {
      HIT_NONE = 2'b00,
      HIT_CTL  = 2'b01,
      HIT_STS  = 2'b10
   } reg_hit_t;

   // Table load progress
   typedef enum logic {
      LOAD_IDLE = 1'b0,
      LOAD_BUSY = 1'b1
   } load_state_t;

endpackage : vc_res_pkg

// ===== src/vc_resource_regs.sv
// Purpose: Control and status registers of the sole channel resource
// Assumes: AXI4-Lite master, one read and one write outstanding at most
// Notes:   Table storage and capability fields sit outside this block
//          Writes to the status word are answered OKAY and change nothing
//          Unmapped addresses are answered with a decode error
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module vc_resource_regs (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // Write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // Write response channel
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Read address channel
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // Read data channel
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Port arbiter side
   output var  logic [2:0]  arb_scheme_select,
   output var  logic        arb_table_load_trigger,
   input  wire logic        arb_table_load_done,
   input  wire logic        arb_table_write,
   // Link layer side
   input  wire logic        flow_init_active
);

   // Decode a byte address to one of the two registers
   // Only word bits take part, so the two low address bits are ignored
   // Shared by the write and the read path
   function automatic vc_res_pkg::reg_hit_t reg_hit(input logic [11:0] addr);
      logic [9:0] word;
      word = addr[11:vc_res_pkg::WORD_LSB];
      if (word == vc_res_pkg::CTL_OFFSET[11:vc_res_pkg::WORD_LSB]) begin
         reg_hit = vc_res_pkg::HIT_CTL;
      end else if (word == vc_res_pkg::STS_OFFSET[11:vc_res_pkg::WORD_LSB]) begin
         reg_hit = vc_res_pkg::HIT_STS;
      end else begin
         reg_hit = vc_res_pkg::HIT_NONE;
      end
   endfunction : reg_hit

   // Write channel state
   logic        awready_ff;
   logic        aw_held_ff;
   logic [11:0] aw_addr_ff;
   logic        wready_ff;
   logic        w_held_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;

   // Read channel state
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   // Register contents
   logic [2:0]  sel_ff;
   logic        load_trig_ff;
   logic        pend_ff;

   // Next-state terms
   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        wr_fire;
   logic        nxt_aw_held;
   logic        nxt_w_held;
   logic        nxt_rvalid;
   logic        ctl_wr;
   logic        sel_lane_on;
   logic [31:0] ctl_word;
   logic [31:0] sts_word;
   logic [31:0] nxt_rdata;
   logic [1:0]  nxt_rresp;

   vc_res_pkg::reg_hit_t wr_hit;
   vc_res_pkg::reg_hit_t rd_hit;


   // Coherency tracking lives in its own module so that the
   // set-wins priority of the stale flag is kept in one place
   arb_table_if tbl ();

   arb_table_tracker u_tracker (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .tbl       (tbl.trk),
      .load_done (arb_table_load_done)
   );

   assign tbl.table_wr = arb_table_write;
   assign tbl.load_req = load_trig_ff;


   // Channel handshakes
   assign aw_take     = s_axi_awvalid && awready_ff;
   assign w_take      = s_axi_wvalid && wready_ff;
   assign ar_take     = s_axi_arvalid && arready_ff;

   // Address and data may arrive in either order; fire once both are held
   // A pending response holds the next write back, so bresp never overruns
   assign wr_fire     = aw_held_ff && w_held_ff && !bvalid_ff;
   assign nxt_aw_held = (aw_held_ff && !wr_fire) || aw_take;
   assign nxt_w_held  = (w_held_ff && !wr_fire) || w_take;
   assign nxt_rvalid  = (rvalid_ff && !s_axi_rready) || ar_take;


   // Write decode uses the held address; read decode the live one,
   // since the read image is sampled in the cycle the address is taken
   assign wr_hit      = reg_hit(aw_addr_ff);
   assign rd_hit      = reg_hit(s_axi_araddr);
   assign ctl_wr      = wr_fire && (wr_hit == vc_res_pkg::HIT_CTL);
   assign sel_lane_on = w_strb_ff[vc_res_pkg::SEL_LANE];

   // Read images of the two registers
   // Fields not assigned below stay zero, so reserved bits cost no storage
   always_comb begin
      ctl_word = vc_res_pkg::WORD_ZERO;
      sts_word = vc_res_pkg::WORD_ZERO;
      ctl_word[vc_res_pkg::SEL_LSB +: vc_res_pkg::SEL_W] = sel_ff;
      ctl_word[vc_res_pkg::CHID_LSB +: vc_res_pkg::CHID_W] = vc_res_pkg::CHID_VAL;
      ctl_word[vc_res_pkg::EN_BIT] = vc_res_pkg::EN_VAL;
      sts_word[vc_res_pkg::STALE_BIT] = tbl.stale;
      sts_word[vc_res_pkg::PEND_BIT] = pend_ff;
   end

   always_comb begin
      nxt_rdata = vc_res_pkg::WORD_ZERO;
      nxt_rresp = vc_res_pkg::RESP_OKAY;
      unique case (rd_hit)
         vc_res_pkg::HIT_CTL: begin
            nxt_rdata = ctl_word;
         end
         vc_res_pkg::HIT_STS: begin
            nxt_rdata = sts_word;
         end
         default: begin
            nxt_rresp = vc_res_pkg::RESP_DECERR;
         end
      endcase
   end

   // Write address capture
   // Ready drops at the taking edge, so a held address cannot be taken twice
   // before the write it belongs to has fired
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
      end else begin
         aw_held_ff <= nxt_aw_held;
         awready_ff <= !nxt_aw_held;
         if (aw_take) begin
            aw_addr_ff <= s_axi_awaddr;
         end
      end
   end

   // Write data capture
   // Same scheme as the address: data may come before, with or after it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wready_ff <= 1'b0;
         w_data_ff <= vc_res_pkg::WORD_ZERO;
         w_strb_ff <= 4'h0;
      end else begin
         w_held_ff <= nxt_w_held;
         wready_ff <= !nxt_w_held;
         if (w_take) begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
      end
   end

   // Write response; status writes are accepted but change nothing
   // The response stands until the master shows bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= vc_res_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         if (wr_hit == vc_res_pkg::HIT_NONE) begin
            bresp_ff <= vc_res_pkg::RESP_DECERR;
         end else begin
            bresp_ff <= vc_res_pkg::RESP_OKAY;
         end
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Arbitration select; the bus cannot check it against capability
   // Limitation: an unadvertised code is stored as written and passed on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_ff <= vc_res_pkg::SEL_RST;
      end else if (ctl_wr && sel_lane_on) begin
         sel_ff <= w_data_ff[vc_res_pkg::SEL_LSB +: vc_res_pkg::SEL_W];
      end
   end

   // one-cycle load pulse
   // The load bit is never stored, which is why it always reads zero;
   // writing zero simply produces no pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_trig_ff <= 1'b0;
      end else begin
         load_trig_ff <= ctl_wr && sel_lane_on && w_data_ff[vc_res_pkg::LOAD_BIT];
      end
   end

   // register the pending level
   // Source runs on this clock, so one register is enough and the
   // status lags the link layer by a single cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= flow_init_active;
      end
   end

   // Read channel; the address is decoded in the cycle it is taken
   // Data are frozen at the taking edge, so a flag that moves while
   // the answer waits does not tear the returned word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b0;
         rdata_ff   <= vc_res_pkg::WORD_ZERO;
         rresp_ff   <= vc_res_pkg::RESP_OKAY;
      end else begin
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= !nxt_rvalid;
         if (ar_take) begin
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
         end
      end
   end


   // Every output is a plain copy of a register
   assign s_axi_awready          = awready_ff;
   assign s_axi_wready           = wready_ff;
   assign s_axi_bvalid           = bvalid_ff;
   assign s_axi_bresp            = bresp_ff;
   assign s_axi_arready          = arready_ff;
   assign s_axi_rvalid           = rvalid_ff;
   assign s_axi_rdata            = rdata_ff;
   assign s_axi_rresp            = rresp_ff;
   assign arb_scheme_select      = sel_ff;
   assign arb_table_load_trigger = load_trig_ff;

endmodule : vc_resource_regs
`default_nettype wire

// ===== verification/tb_vc_resource_regs.sv
// Purpose: Self-checking bench for the channel resource registers
// Assumes: bready and rready held high, so every answer is taken at once
// Notes:   Scenarios run back to back from one sequence
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_vc_resource_regs;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [2:0]  arb_scheme_select;
   logic        arb_table_load_trigger, arb_table_load_done = 1'b0;
   logic        arb_table_write = 1'b0, flow_init_active = 1'b0;
   logic [31:0] rd;
   int          err_total = 0, checks = 0, trig_cnt = 0;

   vc_resource_regs vc_resource_regs_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .arb_scheme_select(arb_scheme_select), .arb_table_load_trigger(arb_table_load_trigger),
      .arb_table_load_done(arb_table_load_done), .arb_table_write(arb_table_write),
      .flow_init_active(flow_init_active));

   initial forever #12.5 aclk = ~aclk;
   always @(posedge aclk) if (arb_table_load_trigger === 1'b1) trig_cnt++;

   task automatic print_verdict;
      $display("Mismatches %0d, comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // Waits only on the answer; the watchdog alone ends a hang
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : axi_read

   task automatic pulse(input logic w, input logic d);
      arb_table_write <= w; arb_table_load_done <= d;
      @(posedge aclk);
      arb_table_write <= 1'b0; arb_table_load_done <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : pulse

   task automatic t_reset;
      axi_read(vc_res_pkg::CTL_OFFSET); `CHK(rd, 32'h8000_0000)
      axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd, 32'h0000_0000)
      `CHK(arb_scheme_select, 3'h0)
   endtask : t_reset

   // Reserved bits other than bit 24 are written as ones and the fixed enable bit as zero to prove they are ignored
   task automatic t_select;
      // bench plays software with every code taken as advertised
      for (int v = 0; v < 8; v++) begin
         axi_write(vc_res_pkg::CTL_OFFSET, 32'h7EF0_FFFF | (v << 17), 4'hF);
         `CHK(resp, vc_res_pkg::RESP_OKAY)
         axi_read(vc_res_pkg::CTL_OFFSET);
         `CHK(rd, 32'h8000_0000 | (v << 17))
         `CHK(arb_scheme_select, 3'(v))
      end
      axi_write(vc_res_pkg::CTL_OFFSET, 32'h0000_0000, 4'hB);
      `CHK(arb_scheme_select, 3'h7)
   endtask : t_select

   task automatic t_pending;
      flow_init_active <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd, 32'h0000_0002)
      flow_init_active <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd, 32'h0000_0000)
   endtask : t_pending

   task automatic t_unmapped;
      axi_read(12'h200); `CHK(resp, vc_res_pkg::RESP_DECERR)
      `CHK(rd, 32'h0000_0000)
      axi_write(12'h200, 32'hFFFF_FFFF, 4'hF); `CHK(resp, vc_res_pkg::RESP_DECERR)
      axi_write(vc_res_pkg::STS_OFFSET, 32'hFFFF_FFFF, 4'hF); `CHK(resp, 2'h0)
      axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd, 32'h0000_0000)
   endtask : t_unmapped

   task automatic load(input int exp_cnt);
      axi_write(vc_res_pkg::CTL_OFFSET, 32'h0001_0000, 4'hF);
      repeat (3) @(posedge aclk);
      `CHK(trig_cnt, exp_cnt)
   endtask : load

   // Select is set to 2 until the first load write clears it: the stale flag is reported whatever the scheme
   task automatic t_stale;
      axi_write(vc_res_pkg::CTL_OFFSET, 32'h0004_0000, 4'hF);
      pulse(1'b1, 1'b0); axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b1)
      pulse(1'b0, 1'b1); axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b1)
      load(1);
      axi_read(vc_res_pkg::CTL_OFFSET); `CHK(rd, 32'h8000_0000)
      axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b1)
      pulse(1'b0, 1'b1); axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b0)
      axi_write(vc_res_pkg::CTL_OFFSET, 32'h0000_0000, 4'hF);
      repeat (3) @(posedge aclk); `CHK(trig_cnt, 1)
      load(2);
      pulse(1'b1, 1'b1); axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b1)
      pulse(1'b0, 1'b1); axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b1)
      load(3);
      pulse(1'b0, 1'b1); axi_read(vc_res_pkg::STS_OFFSET); `CHK(rd[0], 1'b0)
   endtask : t_stale

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_select();
      t_pending();
      t_unmapped();
      t_stale();
      print_verdict();
   end

   // Whole run needs well under two thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      print_verdict();
   end
endmodule : tb_vc_resource_regs

bind vc_resource_regs vc_resource_regs_sva vc_resource_regs_sva_i (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .arb_scheme_select(arb_scheme_select), .arb_table_load_trigger(arb_table_load_trigger));
`default_nettype wire

// ===== verification/vc_resource_regs_sva.sv
// Purpose: Port-level checks for the channel resource registers
// Assumes: Aligned single-word accesses, one read and one write at a time
// Notes:   Helpers remember the last accepted address and write data
`timescale 1ns/1ps
`default_nettype none
module vc_resource_regs_sva (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write side
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   // Read side
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   // Arbiter side
   input wire logic [2:0]  arb_scheme_select,
   input wire logic        arb_table_load_trigger
);
   logic [11:0] wa_ff;
   logic [11:0] ra_ff;
   logic [31:0] wd_ff;
   logic [3:0]  ws_ff;
   logic        rd_ctl;
   logic        rd_sts;
   logic        wr_load;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Separate aw and w handshakes are remembered so either order is judged alike
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wa_ff <= 12'h000;
         ra_ff <= 12'h000;
         wd_ff <= 32'h0000_0000;
         ws_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
         if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
         if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata;
         if (s_axi_wvalid && s_axi_wready) ws_ff <= s_axi_wstrb;
      end
   end

   assign rd_ctl  = s_axi_rvalid && (ra_ff == vc_res_pkg::CTL_OFFSET);
   assign rd_sts  = s_axi_rvalid && (ra_ff == vc_res_pkg::STS_OFFSET);
   assign wr_load = (wa_ff == vc_res_pkg::CTL_OFFSET) && wd_ff[16] && ws_ff[2];

   ctl_enable_a: assert property (rd_ctl |-> s_axi_rdata[31])
      else $error("Channel enable bit reads zero");
   ctl_reserved_a: assert property (rd_ctl |-> s_axi_rdata[30:20] == 11'h000
      && s_axi_rdata[15:0] == 16'h0000) else $error("Fixed control bits not zero");
   load_reads_zero_a: assert property (rd_ctl |-> !s_axi_rdata[16])
      else $error("Load bit reads one");
   ctl_select_a: assert property (rd_ctl |-> s_axi_rdata[19:17] == arb_scheme_select)
      else $error("Select readback differs from output");
   sts_reserved_a: assert property (rd_sts |-> s_axi_rdata[31:2] == 30'h0000_0000)
      else $error("Status reserved bits not zero");
   unmapped_read_a: assert property (s_axi_rvalid && !rd_ctl && !rd_sts
      |-> s_axi_rresp == vc_res_pkg::RESP_DECERR && s_axi_rdata == 32'h0000_0000)
      else $error("Unmapped read not refused");
   select_write_a: assert property ($changed(arb_scheme_select) |-> $rose(s_axi_bvalid)
      && wa_ff == vc_res_pkg::CTL_OFFSET && ws_ff[2] && arb_scheme_select == wd_ff[19:17])
      else $error("Select changed without a control write");
   trig_cause_a: assert property ($rose(arb_table_load_trigger) |-> wr_load)
      else $error("Load pulse without a load write");
   trig_pulse_a: assert property (arb_table_load_trigger |=> !arb_table_load_trigger)
      else $error("Load pulse longer than one cycle");
   trig_follow_a: assert property ($rose(s_axi_bvalid) && wr_load
      |-> ##[0:2] arb_table_load_trigger) else $error("Load write gave no pulse");
endmodule : vc_resource_regs_sva
`default_nettype wire
